// ==== core/scs_supervisor.sv ====
// Purpose: Supply, reset-line and oscillator supervision with converter sequencing.
// Assumes: Supply comparator and reset pin inputs are asynchronous; aux oscillator
//          is a clock port of its own domain; flag reads arrive as mclk pulses.
// Notes:   Each rule below is carried out by the logic of this module; the logic carries no rule tags.
// Summary of operation
// - Internal undervoltage: reset, drivers off, flag set.
// - Clock fail: reset, drivers off, clock flag.
// - Other undervoltage or host reset: keep cause flags.
// - Rail faults: valves off, pump on, setpoints clear.
// - Fault state lasts through reset recovery.
// - Recovery starts when all supplies are good.
// - Internal supply filtered both ways, then recovery.
// - Interface supply filtered both ways, then recovery.
// - Clock check only while reset line high.
// - Stopped or mismatched oscillator causes clock reset.
// - Cause flags clear when read.
// - Clock check restarts after its flag clears.
// - Missing oscillator reported between short and long bases.
// - Mismatch measured over one long window.
// - Aux stop disables only aux and check.
// - Spread enable and depth select deviation.
// - Aux restart may raise the clock flag.
// - Temperature warning is live, no shutdown.
// - Ten-bit results for all converter channels.
// - Each result refreshed near 100 us.
// - Host reset low needs 2 us filter.
// - Recovery period lasts 45 ms.
`timescale 1ns/1ps
module scs_supervisor
   import scs_pkg::*;
#(
   parameter int T2_CYCLES   = T2_CYC,
   parameter int VINT_CYCLES = VINT_FILT_CYC,
   parameter int REC_CYCLES  = REC_CYC,
   parameter int AUX_KHZ     = OSC_NOM_KHZ
)(
   input  wire logic             mclk,
   input  wire logic             rstn,
   input  wire logic             auxClk,
   input  wire logic             vintLowRaw,
   input  wire logic             vccLowRaw,
   input  wire logic             dosvLowRaw,
   input  wire logic             railOverRaw,
   input  wire logic             railUnderRaw,
   input  wire logic             tempWarnRaw,
   input  wire logic             resetLineIn,
   output logic                  resetLineOut,
   output logic                  resetLineOe,
   output logic                  valveEnable,
   output logic                  pumpEnable,
   output logic                  resistiveEnable,
   output logic                  regInitHold,
   output logic                  valveSetpointClear,
   input  wire logic             flagRead,
   output logic      [5:0]       statusWord,
   input  wire logic             auxOscStopCmd,
   input  wire logic             spreadEnable,
   input  wire logic             spreadDepthSelect,
   output logic                  auxOscEnable,
   output logic                  spreadOn,
   output logic                  spreadWide,
   output logic                  adcStart,
   output logic      [3:0]       adcChannel,
   input  wire logic             adcDone,
   input  wire logic [ADC_W-1:0] adcResult,
   input  wire logic [3:0]       resultAddr,
   output logic      [ADC_W-1:0] resultData
);
   // Expected aux edges in one window and the accepted band.
   localparam longint AUX_EXP = longint'(T2_US) * AUX_KHZ / 1000;
   localparam longint AUX_LO  = AUX_EXP * (100 - MISMATCH_PCT) / 100;
   localparam longint AUX_HI  = AUX_EXP * (100 + MISMATCH_PCT) / 100;

   // Gray to binary for the aux count crossing.
   function automatic logic [AUX_CW-1:0] gray2bin(input logic [AUX_CW-1:0] g);
      logic [AUX_CW-1:0] b;
      b = '0;
      for (int i = AUX_CW - 1; i >= 0; i--) begin
         b[i] = g[i] ^ ((i == AUX_CW - 1) ? 1'b0 : b[i+1]);
      end
      return b;
   endfunction : gray2bin

   // Filter length for slot i when the new level is lvl; all in mclk cycles.
   function automatic int filtLimit(input int i, input logic lvl);
      case (i)
         F_VINT:  return VINT_CYCLES;
         F_VCC:   return T1_CYC;
         F_INTERFACE_SUPPLY:  return T1_CYC;
         F_EXT:   return lvl ? EXT_FILT_CYC : 1;
         default: return T2_CYCLES;
      endcase
   endfunction : filtLimit

   // Two-flop synchronisers for pin inputs.
   logic [F_NUM-1:0] rawS1_q, rawS2_q;   // Stage one and two of the comparators.
   logic             lineS1_q, lineS2_q; // Reset line level.
   logic [F_NUM-1:0] rawLvl;             // Synchronised levels, fault = 1.
   logic [F_NUM-1:0] filt_q;             // Filtered fault levels.
   logic [31:0]      fCnt_q [F_NUM];     // Persistence counters.
   logic [F_NUM-1:0] filtPrev_q;         // Previous filtered levels.
   logic             resetDrive_q;       // Device holds the line low.
   logic [31:0]      recCnt_q;           // Recovery counter.
   logic [4:0]       flags_q;            // Reset-cause flags.
   logic [4:0]       flags_d;            // Next reset-cause flags.
   logic [4:0]       setV;               // Flag set events of this cycle.
   logic             clkFail;            // One-cycle clock fault.
   logic             supplyBad;          // Any supervised supply low.
   logic             hostLow;            // Filtered host reset.

   // Pin synchronisers; stage one feeds only stage two.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rawS1_q  <= '0;
         rawS2_q  <= '0;
         lineS1_q <= 1'b1;
         lineS2_q <= 1'b1;
      end else begin
         rawS1_q  <= {tempWarnRaw, railUnderRaw, railOverRaw, ~resetLineIn,
                      dosvLowRaw, vccLowRaw, vintLowRaw};
         rawS2_q  <= rawS1_q;
         lineS1_q <= resetLineIn;
         lineS2_q <= lineS1_q;
      end
   end

   // A low line caused by our own drive is not a host reset.
   always_comb begin
      rawLvl        = rawS2_q;
      rawLvl[F_EXT] = rawS2_q[F_EXT] & ~resetDrive_q;
   end

   // Persistence filters; a level must hold its full count to be taken.
   always_ff @(posedge mclk) begin
      for (int i = 0; i < F_NUM; i++) begin
         if (!rstn) begin
            fCnt_q[i] <= '0;
            filt_q[i] <= 1'b0;
         end else if (rawLvl[i] == filt_q[i]) begin
            fCnt_q[i] <= '0;
         end else if (int'(fCnt_q[i]) >= filtLimit(i, rawLvl[i]) - 1) begin
            filt_q[i] <= rawLvl[i];
            fCnt_q[i] <= '0;
         end else begin
            fCnt_q[i] <= fCnt_q[i] + 32'h1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) filtPrev_q <= '0;
      else filtPrev_q <= filt_q;
   end

   assign supplyBad = filt_q[F_VINT] | filt_q[F_VCC] | filt_q[F_INTERFACE_SUPPLY];
   assign hostLow   = filt_q[F_EXT];

   // Reset drive and recovery: held while a supply is low, then a full
   // recovery period once every supply is good. Power-up runs one recovery.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         resetDrive_q <= 1'b1;
         recCnt_q     <= '0;
      end else if (supplyBad || clkFail) begin
         resetDrive_q <= 1'b1;
         recCnt_q     <= '0;
      end else if (resetDrive_q) begin
         if (int'(recCnt_q) >= REC_CYCLES - 1) begin
            resetDrive_q <= 1'b0;
            recCnt_q     <= '0;
         end else begin
            recCnt_q <= recCnt_q + 32'h1;
         end
      end
   end

   // Open-drain line: the output is always low, the enable pulls it.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         resetLineOut <= 1'b0;
         resetLineOe  <= 1'b1;
      end else begin
         resetLineOut <= 1'b0;
         resetLineOe  <= resetDrive_q;
      end
   end

   // Driver permissions and register initialisation. Rail faults only
   // stop the valves and clear their set points; the pump stays allowed.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         valveEnable        <= 1'b0;
         pumpEnable         <= 1'b0;
         resistiveEnable    <= 1'b0;
         regInitHold        <= 1'b1;
         valveSetpointClear <= 1'b1;
      end else begin
         valveEnable        <= ~(resetDrive_q | hostLow | filt_q[F_OV] | filt_q[F_UV]);
         pumpEnable         <= ~(resetDrive_q | hostLow);
         resistiveEnable    <= ~(resetDrive_q | hostLow);
         regInitHold        <= resetDrive_q | hostLow;
         valveSetpointClear <= resetDrive_q | hostLow | filt_q[F_OV] | filt_q[F_UV];
      end
   end

   // Next cause flags. Each is set on its fault, clears when a read returns
   // it, and a set in the read cycle survives. An internal undervoltage wipes
   // the other causes; a clock fault keeps only the internal one.
   always_comb begin
      setV            = '0;
      setV[FLAG_VINT] = filt_q[F_VINT] & ~filtPrev_q[F_VINT];
      setV[FLAG_VCC]  = filt_q[F_VCC]  & ~filtPrev_q[F_VCC];
      setV[FLAG_INTERFACE_SUPPLY] = filt_q[F_INTERFACE_SUPPLY] & ~filtPrev_q[F_INTERFACE_SUPPLY];
      setV[FLAG_EXT]  = filt_q[F_EXT]  & ~filtPrev_q[F_EXT];
      setV[FLAG_CLK]  = clkFail;
      flags_d = flags_q;
      if (flagRead) flags_d = '0;
      if (setV[FLAG_VINT]) flags_d = '0;
      else if (clkFail) flags_d = flags_d & (5'h01 << FLAG_VINT);
      flags_d = flags_d | setV;
   end

   // Cause flag register; power-up counts as an internal undervoltage.
   always_ff @(posedge mclk) begin
      if (!rstn) flags_q <= FLAGS_RST;
      else flags_q <= flags_d;
   end

   // Status read: cause flags as they stood, temperature warning live.
   always_ff @(posedge mclk) begin
      if (!rstn) statusWord <= '0;
      else if (flagRead) statusWord <= {filt_q[F_TEMP], flags_q};
   end

   // Oscillator controls straight from the command bits.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         auxOscEnable <= 1'b1;
         spreadOn     <= 1'b0;
         spreadWide   <= 1'b0;
      end else begin
         auxOscEnable <= ~auxOscStopCmd;
         spreadOn     <= spreadEnable;
         spreadWide   <= spreadDepthSelect;
      end
   end

   // Aux domain: its reset is synchronised in, then a gray edge counter.
   logic              auxRstS1_q, auxRstS2_q;
   logic [AUX_CW-1:0] auxBin_q, auxGray_q;

   always_ff @(posedge auxClk) begin
      auxRstS1_q <= rstn;
      auxRstS2_q <= auxRstS1_q;
   end

   always_ff @(posedge auxClk) begin
      if (!auxRstS2_q) begin
         auxBin_q  <= '0;
         auxGray_q <= '0;
      end else begin
         auxBin_q  <= auxBin_q + 1'b1;
         auxGray_q <= (auxBin_q + 1'b1) ^ ((auxBin_q + 1'b1) >> 1);
      end
   end

   // Gray count brought into mclk; only one bit changes per aux edge.
   logic [AUX_CW-1:0] grayS1_q, grayS2_q, auxNow, auxPrev_q, auxStart_q;
   logic [31:0]       winCnt_q;  // Window position in mclk cycles.
   logic [31:0]       stallCnt_q; // Cycles with no aux progress.
   logic              monActive; // Monitor allowed to run.
   logic [AUX_CW-1:0] auxDiff;

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         grayS1_q <= '0;
         grayS2_q <= '0;
      end else begin
         grayS1_q <= auxGray_q;
         grayS2_q <= grayS1_q;
      end
   end

   assign auxNow    = gray2bin(grayS2_q);
   assign auxDiff   = auxNow - auxStart_q;
   // Runs with the line high, no pending clock flag and the aux running.
   assign monActive = lineS2_q & ~resetDrive_q & ~flags_q[FLAG_CLK]
                      & ~auxOscStopCmd;

   // Window and stall checks, both timed by the main clock.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         winCnt_q   <= '0;
         stallCnt_q <= '0;
         auxStart_q <= '0;
         auxPrev_q  <= '0;
         clkFail    <= 1'b0;
      end else begin
         auxPrev_q <= auxNow;
         clkFail   <= 1'b0;
         if (!monActive || clkFail) begin
            winCnt_q   <= '0;
            stallCnt_q <= '0;
            auxStart_q <= auxNow;
         end else begin
            if (auxNow != auxPrev_q) stallCnt_q <= '0;
            else if (int'(stallCnt_q) >= T1_CYC - 1) clkFail <= 1'b1;
            else stallCnt_q <= stallCnt_q + 32'h1;
            if (int'(winCnt_q) >= T2_CYCLES - 1) begin
               winCnt_q   <= '0;
               auxStart_q <= auxNow;
               if (longint'(auxDiff) < AUX_LO || longint'(auxDiff) > AUX_HI)
                  clkFail <= 1'b1;
            end else begin
               winCnt_q <= winCnt_q + 32'h1;
            end
         end
      end
   end

   // Converter sequencer: one start per pacing slot once the previous
   // result is in, so a full sweep takes about the refresh time.
   logic [15:0] paceCnt_q; // Pacing counter.
   logic        adcBusy_q; // Conversion in flight.

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         paceCnt_q  <= '0;
         adcBusy_q  <= 1'b0;
         adcStart   <= 1'b0;
         adcChannel <= '0;
      end else begin
         adcStart <= 1'b0;
         if (int'(paceCnt_q) < ADC_PACE_CYC - 1) paceCnt_q <= paceCnt_q + 16'h1;
         if (adcBusy_q && adcDone) begin
            adcBusy_q <= 1'b0;
            if (int'(adcChannel) == ADC_CHANNELS - 1) adcChannel <= '0;
            else adcChannel <= adcChannel + 4'h1;
         end else if (!adcBusy_q && int'(paceCnt_q) >= ADC_PACE_CYC - 1) begin
            adcStart  <= 1'b1;
            adcBusy_q <= 1'b1;
            paceCnt_q <= '0;
         end
      end
   end

   // Results land in the store as each conversion completes.
   scs_result_mem uMem (
      .mclk     (mclk),
      .rstn     (rstn),
      .wrEn     (adcBusy_q & adcDone),
      .wrAddr   (adcChannel),
      .wrData   (adcResult),
      .rdAddr   (resultAddr),
      .rdData_q (resultData)
   );
endmodule : scs_supervisor

// ==== core/scs_pkg.sv ====
// Purpose: Shared constants for the supply and clock supervisor.
// Assumes: Main clock mclk at 50 MHz; all times given in their printed unit.
// Notes:   Counts above 4096 cycles are defaults for top-level parameters.
package scs_pkg;
   // Main clock rate in MHz.
   localparam int MCLK_MHZ = 50;
   // Short time base, in ns, and its cycle count.
   localparam int T1_NS  = 18200;
   localparam int T1_CYC = (T1_NS * MCLK_MHZ + 999) / 1000;
   // Long time base, in us, and its cycle count.
   localparam int T2_US  = 293;
   localparam int T2_CYC = T2_US * MCLK_MHZ;
   // Internal supply filter time, in us.
   localparam int VINT_FILT_US  = 1000;
   localparam int VINT_FILT_CYC = VINT_FILT_US * MCLK_MHZ;
   // Host reset falling-edge filter, in ns.
   localparam int EXT_FILT_NS  = 2000;
   localparam int EXT_FILT_CYC = (EXT_FILT_NS * MCLK_MHZ + 999) / 1000;
   // Reset recovery time, in ms.
   localparam int REC_MS  = 45;
   localparam int REC_CYC = REC_MS * 1000 * MCLK_MHZ;
   // Converter: channel count, refresh target in us, pacing per channel.
   localparam int ADC_W         = 10;
   localparam int ADC_CHANNELS  = 13;
   localparam int ADC_REFRESH_US = 100;
   localparam int ADC_PACE_CYC  = ADC_REFRESH_US * MCLK_MHZ / ADC_CHANNELS;
   // Oscillator nominal frequency and mismatch limit.
   localparam int OSC_NOM_KHZ  = 14000;
   localparam int MISMATCH_PCT = 25;
   // Spread deviations selected by the depth bit.
   localparam int SPREAD_NARROW_KHZ = 350;
   localparam int SPREAD_WIDE_KHZ   = 700;
   // Flag positions in the reset-cause vector.
   localparam int FLAG_VINT = 0;
   localparam int FLAG_VCC  = 1;
   localparam int FLAG_INTERFACE_SUPPLY = 2;
   localparam int FLAG_EXT  = 3;
   localparam int FLAG_CLK  = 4;
   localparam logic [4:0] FLAGS_RST = 5'h01;
   // Filter slots.
   localparam int F_VINT = 0;
   localparam int F_VCC  = 1;
   localparam int F_INTERFACE_SUPPLY = 2;
   localparam int F_EXT  = 3;
   localparam int F_OV   = 4;
   localparam int F_UV   = 5;
   localparam int F_TEMP = 6;
   localparam int F_NUM  = 7;
   // Aux edge counter width.
   localparam int AUX_CW = 16;
endpackage : scs_pkg

// ==== core/scs_result_mem.sv ====
// Purpose: Result store for converter channels, read data registered.
// Assumes: One write port and one read port on the same clock.
// Notes:   Contents clear on reset so unread channels show zero.
`timescale 1ns/1ps
module scs_result_mem
   import scs_pkg::*;
(
   input  wire logic             mclk,
   input  wire logic             rstn,
   input  wire logic             wrEn,
   input  wire logic [3:0]       wrAddr,
   input  wire logic [ADC_W-1:0] wrData,
   input  wire logic [3:0]       rdAddr,
   output logic      [ADC_W-1:0] rdData_q
);
   // One word per channel.
   logic [ADC_W-1:0] mem_q [ADC_CHANNELS];

   // Write side; addresses past the last channel are dropped.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         for (int i = 0; i < ADC_CHANNELS; i++) mem_q[i] <= '0;
      end else if (wrEn && (int'(wrAddr) < ADC_CHANNELS)) begin
         mem_q[wrAddr] <= wrData;
      end
   end

   // Registered read; out-of-range reads return zero.
   always_ff @(posedge mclk) begin
      if (!rstn) rdData_q <= '0;
      else if (int'(rdAddr) < ADC_CHANNELS) rdData_q <= mem_q[rdAddr];
      else rdData_q <= '0;
   end
endmodule : scs_result_mem

// ==== sim/scs_supervisor_sva.sv ====
// Purpose: Concurrent checks on the supervisor outputs.
// Assumes: One mclk domain; rstn synchronous and active low.
// Notes:   Bound to every supervisor instance by the statement at the foot.
`timescale 1ns/1ps
module scs_supervisor_chk (
   input wire logic       mclk,
   input wire logic       rstn,
   input wire logic       resetLineOe,
   input wire logic       valveEnable,
   input wire logic       pumpEnable,
   input wire logic       resistiveEnable,
   input wire logic       regInitHold,
   input wire logic       valveSetpointClear,
   input wire logic       flagRead,
   input wire logic [5:0] statusWord,
   input wire logic       auxOscStopCmd,
   input wire logic       auxOscEnable,
   input wire logic       spreadEnable,
   input wire logic       spreadDepthSelect,
   input wire logic       spreadOn,
   input wire logic       spreadWide,
   input wire logic       adcDone,
   input wire logic [3:0] adcChannel
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   // While the line is pulled low by the device every driver must be off.
   a_oe_drivers_off: assert property (resetLineOe |->
      !valveEnable && !pumpEnable && !resistiveEnable)
      else $error("driver enabled while the device holds the line low");
   a_oe_init_hold: assert property (resetLineOe |-> regInitHold)
      else $error("registers released while the line is held");
   // A cleared set point can never leave a valve running.
   a_valve_clear_off: assert property (valveSetpointClear |-> !valveEnable)
      else $error("valve on with set point cleared");
   a_spread_follow: assert property (1'b1 |=> spreadOn == $past(spreadEnable))
      else $error("spread enable not followed");
   a_depth_follow: assert property (1'b1 |=> spreadWide == $past(spreadDepthSelect))
      else $error("spread depth not followed");
   a_aux_stop_off: assert property (auxOscStopCmd |=> !auxOscEnable)
      else $error("aux oscillator left running");
   // The snapshot only moves after a read, so it must hold steady in every cycle with no read.
   a_status_stands: assert property (!flagRead |=> $stable(statusWord))
      else $error("status changed without a read");
   a_adc_advance: assert property (adcDone && adcChannel < 4'hC |=>
      adcChannel == $past(adcChannel) + 4'h1)
      else $error("converter channel did not advance");
   a_adc_wrap: assert property (adcDone && adcChannel == 4'hC |=> adcChannel == 4'h0)
      else $error("converter channel did not wrap");
   a_adc_range: assert property (adcChannel <= 4'hC)
      else $error("converter channel out of range");
   // A recovery is far longer than eight cycles, so a short blip is a fault.
   a_oe_min_hold: assert property ($rose(resetLineOe) |=> resetLineOe [*8])
      else $error("line drive dropped too soon");
endmodule : scs_supervisor_chk

bind scs_supervisor scs_supervisor_chk scs_supervisor_chk_inst (.mclk, .rstn, .resetLineOe,
   .valveEnable, .pumpEnable, .resistiveEnable, .regInitHold, .valveSetpointClear, .flagRead,
   .statusWord, .auxOscStopCmd, .auxOscEnable, .spreadEnable, .spreadDepthSelect, .spreadOn,
   .spreadWide, .adcDone, .adcChannel);

// ==== sim/scs_host_model.sv ====
// Purpose: Far side of the supervisor: shared reset line and converter.
// Assumes: Line has a pull-up; converter answers after a channel-dependent delay.
// Notes:   Odd channels answer slowly to exercise a late done.
`timescale 1ns/1ps
module scs_host_model
   import scs_pkg::*;
(
   input  wire logic             mclk,
   input  wire logic             resetLineOe,
   input  wire logic             hostPull,
   output logic                  resetLineIn,
   input  wire logic             adcStart,
   input  wire logic [3:0]       adcChannel,
   output logic                  adcDone,
   output logic      [ADC_W-1:0] adcResult
);
   logic [3:0] ch; // Channel latched at start.
   // Open drain line: low when either party pulls, else the pull-up wins.
   assign resetLineIn = !(resetLineOe || hostPull);
   // Converter answers once per start; the result is scrambled once done drops.
   initial begin
      adcDone = 1'b0;
      adcResult = '1;
      forever begin
         @(posedge mclk);
         if (adcStart === 1'b1) begin
            ch = adcChannel;
            repeat (ch[0] ? 40 : 1) @(posedge mclk);
            adcDone <= 1'b1;
            adcResult <= {ch, 6'h2A};
            @(posedge mclk);
            adcDone <= 1'b0;
            adcResult <= ~{ch, 6'h2A};
         end
      end
   end
endmodule : scs_host_model

// ==== sim/tb_scs_supervisor.sv ====
// Purpose: Self-checking bench for the supply and clock supervisor.
// Assumes: Shortened windows; aux clock 80 ns so AUX_KHZ scales the count band.
// Notes:   Ends through giveVerdict from the main sequence or the watchdog.
`timescale 1ns/1ps
module tb_scs_supervisor;
   import scs_pkg::*;
   localparam int T2C = 200;  // Shortened long window.
   localparam int VC = 100;   // Shortened internal supply filter.
   localparam int RC = 300;   // Shortened recovery.
   localparam int AUXK = 171; // Gives fifty expected aux edges per window.
   logic mclk = 1'b0, auxClk = 1'b0, rstn = 1'b0, auxRun = 1'b1;
   logic [2:0] uvRaw = 3'h0;
   logic [1:0] railRaw = 2'h0;
   logic tempWarnRaw = 1'b0, flagRead = 1'b0, hostPull = 1'b0, auxOscStopCmd = 1'b0;
   logic spreadEnable = 1'b0, spreadDepthSelect = 1'b0;
   logic [3:0] resultAddr = 4'h0;
   logic resetLineIn, resetLineOe, valveEnable, pumpEnable, resistiveEnable, regInitHold;
   logic valveSetpointClear, auxOscEnable, spreadOn, spreadWide, adcStart, adcDone;
   logic resetLineOut; // Open-drain data level, always low.
   logic [5:0] statusWord;
   logic [3:0] adcChannel;
   logic [ADC_W-1:0] adcResult, resultData;
   logic [2:0] drv;
   int badCount = 0, nCompared = 0, i, filt, auxHalf = 40;
   assign drv = {valveEnable, pumpEnable, resistiveEnable};
   initial forever #10 mclk = ~mclk;
   // Aux clock, phase offset from mclk; it stands still while stopped.
   initial begin
      #7;
      forever begin
         #(auxHalf);
         if (auxRun) auxClk = ~auxClk;
      end
   end
   scs_supervisor #(.T2_CYCLES(T2C), .VINT_CYCLES(VC), .REC_CYCLES(RC), .AUX_KHZ(AUXK))
      scs_supervisor_inst (.mclk, .rstn, .auxClk, .vintLowRaw(uvRaw[0]), .vccLowRaw(uvRaw[1]),
      .dosvLowRaw(uvRaw[2]), .railOverRaw(railRaw[0]), .railUnderRaw(railRaw[1]), .tempWarnRaw,
      .resetLineIn, .resetLineOut, .resetLineOe, .valveEnable, .pumpEnable, .resistiveEnable,
      .regInitHold, .valveSetpointClear, .flagRead, .statusWord, .auxOscStopCmd, .spreadEnable,
      .spreadDepthSelect, .auxOscEnable, .spreadOn, .spreadWide, .adcStart, .adcChannel,
      .adcDone, .adcResult, .resultAddr, .resultData);
   scs_host_model scs_host_model_inst (.mclk, .resetLineOe, .hostPull, .resetLineIn, .adcStart,
      .adcChannel, .adcDone, .adcResult);
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      nCompared++;
      if (seen !== exp) begin
         badCount++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc
   // Bounded wait for the line drive to reach a level.
   task automatic waitOe(input logic v, input int lim);
      for (int k = 0; k < lim && resetLineOe !== v; k++) cyc(1);
      check("line drive", resetLineOe, v);
   endtask : waitOe
   // One read pulse; the snapshot lands one edge after it is taken.
   task automatic readFlags(input logic [5:0] exp, input logic [5:0] mask = 6'h3F);
      @(posedge mclk);
      flagRead <= 1'b1;
      @(posedge mclk);
      flagRead <= 1'b0;
      cyc(1);
      check("status", statusWord & mask, exp);
   endtask : readFlags
   task giveVerdict;
      $display("Compared %0d, mismatches %0d", nCompared, badCount);
      if (badCount == 0 && nCompared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : giveVerdict
   initial begin
      repeat (90000) @(posedge mclk);
      badCount++;
      giveVerdict();
   end
   initial begin
      repeat (5) @(posedge auxClk);
      @(posedge mclk);
      rstn <= 1'b1;
      cyc(RC - 20);
      check("recovery", resetLineOe, 1'b1);
      waitOe(1'b0, 80);
      check("drivers on", {drv, regInitHold}, 4'hE);
      readFlags(6'h01);
      readFlags(6'h00);
      // Dips shorter than every filter must pass unseen.
      uvRaw <= 3'h7;
      cyc(50);
      uvRaw <= 3'h0;
      cyc(20);
      check("short dip", resetLineOe, 1'b0);
      for (i = 0; i < 3; i++) begin
         filt = (i == 0) ? VC : T1_CYC;
         uvRaw[i] <= 1'b1;
         waitOe(1'b1, filt + 20);
         check("drivers off", drv, 3'h0);
         check("line out", resetLineOut, 1'b0);
         uvRaw[i] <= 1'b0;
         cyc(filt + RC - 30);
         check("fault held", resetLineOe, 1'b1);
         waitOe(1'b0, 100);
         readFlags(6'h01 << i);
      end
      // Recovery must wait for the last supply to come good.
      uvRaw <= 3'h6;
      waitOe(1'b1, T1_CYC + 20);
      uvRaw <= 3'h4;
      cyc(2 * T1_CYC + RC);
      check("recovery waits", resetLineOe, 1'b1);
      uvRaw <= 3'h0;
      waitOe(1'b0, T1_CYC + RC + 40);
      readFlags(6'h06);
      hostPull <= 1'b1;
      cyc(50);
      hostPull <= 1'b0;
      cyc(10);
      check("host glitch", drv, 3'h7);
      hostPull <= 1'b1;
      cyc(130);
      check("host reset", {drv, regInitHold}, 4'h1);
      hostPull <= 1'b0;
      cyc(10);
      check("host release", drv, 3'h7);
      readFlags(6'h08);
      for (i = 0; i < 2; i++) begin
         railRaw[i] <= 1'b1;
         cyc(T2C + 10);
         check("rail fault", {drv, resetLineOe, valveSetpointClear}, 5'h0D);
         railRaw[i] <= 1'b0;
         cyc(T2C + 10);
         check("rail good", drv, 3'h7);
      end
      tempWarnRaw <= 1'b1;
      cyc(T2C + 10);
      readFlags(6'h20);
      check("no shutdown", drv, 3'h7);
      tempWarnRaw <= 1'b0;
      cyc(T2C + 10);
      readFlags(6'h00);
      for (i = 0; i < 4; i++) begin
         {spreadEnable, spreadDepthSelect} <= i[1:0];
         cyc(2);
         check("spread", {spreadOn, spreadWide}, i[1:0]);
      end
      // With the check off, a dead aux clock must not reset anything.
      auxOscStopCmd <= 1'b1;
      cyc(2);
      check("aux off", auxOscEnable, 1'b0);
      auxRun = 1'b0;
      cyc(3000);
      check("no clock reset", {drv, resetLineOe}, 4'hE);
      auxRun = 1'b1;
      auxOscStopCmd <= 1'b0;
      cyc(2 * T2C + 1000);
      waitOe(1'b0, RC + 1000);
      readFlags(6'h00, 6'h2F);
      auxRun = 1'b0;
      waitOe(1'b1, 2 * T2C + 80);
      check("clock fail off", drv, 3'h0);
      auxRun = 1'b1;
      auxHalf = 20;
      waitOe(1'b0, RC + 100);
      cyc(3 * T2C);
      check("check waits read", resetLineOe, 1'b0);
      readFlags(6'h10);
      waitOe(1'b1, 2 * T2C + 20);
      auxHalf = 40;
      waitOe(1'b0, RC + 100);
      readFlags(6'h10);
      for (i = 0; i < 13; i++) begin
         resultAddr <= i[3:0];
         cyc(2);
         check("adc result", resultData, {i[3:0], 6'h2A});
      end
      giveVerdict();
   end
endmodule : tb_scs_supervisor
